// [pkg/uabw_pkg.sv]
// Purpose: Shared constants for the async serial transceiver and its remote node
// Assumes: 200 MHz core clock, 16x oversampling not used (one divisor tick per bit)
// Notes:   Register offsets index the device's own control port
package uabw_pkg;
  localparam int CLK_MHZ = 200;
  // Register map of the device's control port
  localparam logic [3:0] REG_CONTROL_0    = 4'h0;
  localparam logic [3:0] REG_CONTROL_1    = 4'h1;
  localparam logic [3:0] REG_CONTROL_2    = 4'h2;
  localparam logic [3:0] REG_DIVISOR_LOW  = 4'h3;
  localparam logic [3:0] REG_DIVISOR_HIGH = 4'h4;
  localparam logic [3:0] REG_TX_BUFFER    = 4'h5;
  localparam logic [3:0] REG_RX_BUFFER    = 4'h6;
  localparam logic [3:0] REG_ERROR_FLAGS  = 4'h7;
  localparam logic [3:0] REG_ERROR_IE     = 4'h8;
  localparam logic [3:0] REG_MODULE_FLAGS = 4'h9;
  localparam logic [3:0] REG_STATUS       = 4'ha;
  // serial_control_0 fields
  localparam int C0_MODE_LSB    = 0;   // 3-bit format
  localparam int C0_TRANSMIT_ENABLE_BIT        = 5;
  localparam int C0_RXEN        = 4;
  localparam int C0_AUTOBAUD_ENABLE       = 6;
  localparam int C0_EN          = 7;
  // serial_control_1 fields
  localparam int C1_WAKE        = 0;
  localparam int C1_INTEN       = 1;   // module interrupt enable
  localparam int C1_ERRIE       = 2;   // module error interrupt enable
  localparam int C1_PERIPH      = 3;
  localparam int C1_GLOBAL      = 4;
  localparam int C1_SLEEP       = 5;
  // serial_control_2 fields
  localparam int C2_TX_POLARITY_INVERT       = 0;
  localparam int C2_STOP2       = 1;
  // error flags
  localparam int EF_AUTOBAUD_OVERFLOW_FLAG      = 0;
  localparam int EF_FRAME       = 1;
  localparam int EF_PARITY      = 2;
  localparam int EF_OVERRUN     = 3;
  // module flags
  localparam int MF_AUTOBAUD_DONE_FLAG       = 0;
  localparam int MF_WAKE_EVENT_FLAG        = 1;
  localparam int MF_RXIF        = 2;
  // status
  localparam int ST_RXIDLE      = 0;
  localparam int ST_TXIDLE      = 1;
  // Formats
  localparam logic [2:0] FMT_8BIT  = 3'h0;
  localparam logic [2:0] FMT_7BIT  = 3'h1;
  localparam logic [2:0] FMT_EVEN  = 3'h2;
  localparam logic [2:0] FMT_ODD   = 3'h3;
  localparam logic [2:0] FMT_ADDR  = 3'h4;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;
  localparam int ABD_FALL_EDGES = 5;
endpackage

// [pkg/uabw_link_if.sv]
// Purpose: Two-wire async serial link between device and remote node
// Assumes: Both ends run on the same core clock in simulation
// Notes:   Lines are push-pull; idle mark is high
`timescale 1ns/1ps
interface uabw_link_if;
  logic dev_tx;   // device to remote
  logic dev_rx;   // remote to device
  modport device (output dev_tx, input dev_rx);
  modport remote (input dev_tx, output dev_rx);
endinterface

// [rtl/uabw_device.sv]
// Purpose: Async serial transceiver with auto-baud and wake-on-break
// Assumes: One divisor tick per bit time; rx is synchronised by two flops
// Notes:   Sleep bit in serial_control_1 gates the core; the wake detector keeps watching rx
`timescale 1ns/1ps
module uabw_device (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Interrupt request to the core
  output logic            irq_o,
  // Serial link
  uabw_link_if.device     link
);
  typedef enum logic [1:0] {UABW_IDLE, UABW_START, UABW_DATA, UABW_STOP} uabw_state_type;

  logic [7:0]  ctrl0, ctrl1, ctrl2, txbuf, rxbuf, errf, errie, modf;
  logic [15:0] divisor;
  logic        txbuf_full;
  logic        rx_s1, rx_s2, rx_prev;
  logic        wr_hit;
  logic        sleeping;

  assign wr_hit   = wr_i;
  assign sleeping = ctrl1[uabw_pkg::C1_SLEEP];

  // Ninth bit count and value, shared by both directions
  function automatic logic [3:0] frame_bits(input logic [2:0] fmt);
    case (fmt)
      uabw_pkg::FMT_7BIT: frame_bits = 4'h7;
      uabw_pkg::FMT_8BIT: frame_bits = 4'h8;
      default:            frame_bits = 4'h9;
    endcase
  endfunction

  function automatic logic ninth_bit(input logic [2:0] fmt, input logic [7:0] d, input logic addr);
    case (fmt)
      uabw_pkg::FMT_EVEN: ninth_bit = ^d;
      uabw_pkg::FMT_ODD:  ninth_bit = ~(^d);
      default:            ninth_bit = addr;
    endcase
  endfunction

  always_ff @(posedge core_clk_i) begin
    rx_s1 <= link.dev_rx;
    rx_s2 <= rx_s1;
    rx_prev <= rx_s2;
  end

  // Transmit baud tick; the receiver keeps its own counter; halts while asleep
  logic [15:0] tx_cnt, rx_cnt;
  logic        tx_tick;
  assign tx_tick = (tx_cnt == divisor) && !sleeping;

  // Transmitter
  uabw_state_type tx_state;
  logic [8:0]  tx_shift;
  logic [3:0]  tx_bit;
  logic        tx_stop_n;
  logic        tx_line;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_state <= UABW_IDLE;
      tx_shift <= 9'h000;
      tx_bit   <= 4'h0;
      tx_cnt   <= 16'h0000;
      tx_line  <= 1'b1;
      tx_stop_n <= 1'b0;
    end else if (!sleeping) begin
      tx_cnt <= (tx_state == UABW_IDLE || tx_tick) ? 16'h0000 : tx_cnt + 16'h0001;
      case (tx_state)
        UABW_IDLE: begin
          tx_line <= 1'b1;
          if (txbuf_full && ctrl0[uabw_pkg::C0_EN] && ctrl0[uabw_pkg::C0_TRANSMIT_ENABLE_BIT]) begin
            tx_shift <= {ninth_bit(ctrl0[2:0], txbuf, txbuf[7]), txbuf};
            tx_state <= UABW_START;
            tx_line  <= 1'b0;
          end
        end
        UABW_START: if (tx_tick) begin
          tx_line  <= tx_shift[0];
          tx_shift <= {1'b0, tx_shift[8:1]};
          tx_bit   <= 4'h1;
          tx_state <= UABW_DATA;
        end
        UABW_DATA: if (tx_tick) begin
          if (tx_bit == frame_bits(ctrl0[2:0])) begin
            tx_line  <= 1'b1;
            tx_stop_n <= ctrl2[uabw_pkg::C2_STOP2];
            tx_state <= UABW_STOP;
          end else begin
            tx_line  <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[8:1]};
            tx_bit   <= tx_bit + 4'h1;
          end
        end
        UABW_STOP: if (tx_tick) begin
          if (tx_stop_n) tx_stop_n <= 1'b0;
          else tx_state <= UABW_IDLE;
        end
        default: tx_state <= UABW_IDLE;
      endcase
    end
  end
  // Combinational so polarity acts at once
  assign link.dev_tx = tx_line ^ ctrl2[uabw_pkg::C2_TX_POLARITY_INVERT];

  // Receiver; wake mode holds it idle
  uabw_state_type rx_state;
  logic [8:0]  rx_shift;
  logic [3:0]  rx_bit;
  logic        rx_done, rx_frame_err, rx_par_err;
  logic [15:0] half_div;
  logic        wake_mode;
  assign half_div  = {1'b0, divisor[15:1]};
  assign wake_mode = ctrl1[uabw_pkg::C1_WAKE] && ctrl1[uabw_pkg::C1_INTEN];
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rx_state <= UABW_IDLE;
      rx_shift <= 9'h000;
      rx_bit   <= 4'h0;
      rx_cnt   <= 16'h0000;
      rx_done  <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!sleeping) begin
        rx_cnt <= rx_cnt + 16'h0001;
        case (rx_state)
          UABW_IDLE: begin
            rx_cnt <= 16'h0000;
            if (!rx_s2 && !wake_mode && ctrl0[uabw_pkg::C0_EN] && ctrl0[uabw_pkg::C0_RXEN]
                && !ctrl0[uabw_pkg::C0_AUTOBAUD_ENABLE])
              rx_state <= UABW_START;
          end
          UABW_START: if (rx_cnt == half_div) begin
            rx_cnt   <= 16'h0000;
            rx_bit   <= 4'h0;
            rx_state <= rx_s2 ? UABW_IDLE : UABW_DATA;
          end
          UABW_DATA: if (rx_cnt == divisor) begin
            rx_cnt   <= 16'h0000;
            rx_shift <= {rx_s2, rx_shift[8:1]};
            rx_bit   <= rx_bit + 4'h1;
            if (rx_bit + 4'h1 == frame_bits(ctrl0[2:0])) rx_state <= UABW_STOP;
          end
          UABW_STOP: if (rx_cnt == divisor) begin
            rx_done      <= 1'b1;
            rx_frame_err <= !rx_s2;
            rx_state     <= UABW_IDLE;
          end
          default: rx_state <= UABW_IDLE;
        endcase
      end
    end
  end
  // Align received word to bit 0 by format
  logic [8:0] rx_word;
  always_comb begin
    case (frame_bits(ctrl0[2:0]))
      4'h7:    rx_word = {2'b00, rx_shift[8:2]};
      4'h8:    rx_word = {1'b0, rx_shift[8:1]};
      default: rx_word = rx_shift;
    endcase
  end
  assign rx_par_err = (ctrl0[2:0] == uabw_pkg::FMT_EVEN || ctrl0[2:0] == uabw_pkg::FMT_ODD)
                      && (rx_word[8] != ninth_bit(ctrl0[2:0], rx_word[7:0], 1'b0));

  // Auto-baud measurement over five falling edges
  logic [2:0]  abd_edges;
  logic [16:0] abd_cnt;
  logic        abd_ovf_seen, abd_finish;
  logic        rx_fall, rx_rise;
  assign rx_fall    = rx_prev && !rx_s2;
  assign rx_rise    = !rx_prev && rx_s2;
  assign abd_finish = ctrl0[uabw_pkg::C0_AUTOBAUD_ENABLE] && rx_fall
                      && abd_edges == 3'(uabw_pkg::ABD_FALL_EDGES - 1);
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !ctrl0[uabw_pkg::C0_AUTOBAUD_ENABLE]) begin
      abd_edges <= 3'h0;
      abd_cnt   <= 17'h00000;
      abd_ovf_seen <= 1'b0;
    end else if (!sleeping) begin
      if (rx_fall) abd_edges <= abd_edges + 3'h1;
      if (abd_edges != 3'h0 && !abd_cnt[16]) abd_cnt <= abd_cnt + 17'h00001;
      if (abd_cnt[16]) abd_ovf_seen <= 1'b1;
    end
  end

  // Wake detection; rx low in wake mode is the event
  logic wake_event, wake_end, wake_armed;
  assign wake_event = wake_mode && !rx_s2 && !wake_armed;
  assign wake_end   = wake_mode && wake_armed && rx_rise;
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !wake_mode) wake_armed <= 1'b0;
    else if (wake_event) wake_armed <= 1'b1;
  end

  // Control registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl0 <= 8'h00;
      ctrl1 <= 8'h00;
      ctrl2 <= 8'h00;
      divisor <= uabw_pkg::DIVISOR_RESET;
      errie <= 8'h00;
    end else begin
      if (wr_hit && addr_i == uabw_pkg::REG_CONTROL_0) ctrl0 <= wdata_i;
      if (wr_hit && addr_i == uabw_pkg::REG_CONTROL_1) ctrl1 <= wdata_i;
      if (wr_hit && addr_i == uabw_pkg::REG_CONTROL_2) ctrl2 <= wdata_i;
      if (wr_hit && addr_i == uabw_pkg::REG_ERROR_IE) errie <= wdata_i;
      if (wr_hit && addr_i == uabw_pkg::REG_DIVISOR_LOW) divisor[7:0] <= wdata_i;
      if (wr_hit && addr_i == uabw_pkg::REG_DIVISOR_HIGH) divisor[15:8] <= wdata_i;
      if (abd_finish) begin
        ctrl0[uabw_pkg::C0_AUTOBAUD_ENABLE] <= 1'b0;
        if (!abd_ovf_seen && !abd_cnt[16])
          divisor <= abd_cnt[15:0] >> 3;
      end
      if (wake_end) ctrl1[uabw_pkg::C1_WAKE] <= 1'b0;
    end
  end

  // Flags: hardware set wins over software clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      errf <= 8'h00;
      modf <= 8'h00;
      txbuf <= 8'h00;
      txbuf_full <= 1'b0;
      rxbuf <= 8'h00;
    end else begin
      if (wr_hit && addr_i == uabw_pkg::REG_ERROR_FLAGS) errf <= errf & wdata_i;
      if (wr_hit && addr_i == uabw_pkg::REG_MODULE_FLAGS) modf <= modf & wdata_i;
      if (ctrl0[uabw_pkg::C0_AUTOBAUD_ENABLE] && abd_cnt[16]) errf[uabw_pkg::EF_AUTOBAUD_OVERFLOW_FLAG] <= 1'b1;
      if (abd_finish) modf[uabw_pkg::MF_AUTOBAUD_DONE_FLAG] <= 1'b1;
      if (wake_event) modf[uabw_pkg::MF_WAKE_EVENT_FLAG] <= 1'b1;
      if (rx_done) begin
        rxbuf <= rx_word[7:0];
        modf[uabw_pkg::MF_RXIF] <= 1'b1;
        if (rx_frame_err || !rx_s2) errf[uabw_pkg::EF_FRAME] <= 1'b1;
        if (rx_par_err) errf[uabw_pkg::EF_PARITY] <= 1'b1;
        if (modf[uabw_pkg::MF_RXIF]) errf[uabw_pkg::EF_OVERRUN] <= 1'b1;
      end
      if (rd_i && addr_i == uabw_pkg::REG_RX_BUFFER) modf[uabw_pkg::MF_RXIF] <= rx_done;
      if (wr_hit && addr_i == uabw_pkg::REG_TX_BUFFER) begin
        txbuf <= wdata_i;
        txbuf_full <= 1'b1;
      end else if (tx_state == UABW_IDLE && ctrl0[uabw_pkg::C0_EN] && ctrl0[uabw_pkg::C0_TRANSMIT_ENABLE_BIT] && !sleeping)
        txbuf_full <= 1'b0;
    end
  end

  // Interrupt; wake path is not gated by sleep
  logic int_gate;
  assign int_gate = ctrl1[uabw_pkg::C1_PERIPH] && ctrl1[uabw_pkg::C1_GLOBAL];
  assign irq_o = int_gate && ((errf[uabw_pkg::EF_AUTOBAUD_OVERFLOW_FLAG] && errie[uabw_pkg::EF_AUTOBAUD_OVERFLOW_FLAG]
                               && ctrl1[uabw_pkg::C1_ERRIE])
                              || ((modf[uabw_pkg::MF_WAKE_EVENT_FLAG] || modf[uabw_pkg::MF_AUTOBAUD_DONE_FLAG])
                                  && ctrl1[uabw_pkg::C1_INTEN]));

  // Read port: data one cycle after strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) rdata_o <= 8'h00;
    else if (rd_i) begin
      case (addr_i)
        uabw_pkg::REG_CONTROL_0:    rdata_o <= ctrl0;
        uabw_pkg::REG_CONTROL_1:    rdata_o <= ctrl1;
        uabw_pkg::REG_CONTROL_2:    rdata_o <= ctrl2;
        uabw_pkg::REG_DIVISOR_LOW:  rdata_o <= divisor[7:0];
        uabw_pkg::REG_DIVISOR_HIGH: rdata_o <= divisor[15:8];
        uabw_pkg::REG_RX_BUFFER:    rdata_o <= rxbuf;
        uabw_pkg::REG_ERROR_FLAGS:  rdata_o <= errf;
        uabw_pkg::REG_ERROR_IE:     rdata_o <= errie;
        uabw_pkg::REG_MODULE_FLAGS: rdata_o <= modf;
        uabw_pkg::REG_STATUS:       rdata_o <= {6'h00, tx_state == UABW_IDLE && !txbuf_full,
                                                rx_state == UABW_IDLE};
        default:                    rdata_o <= 8'h00;
      endcase
    end else rdata_o <= 8'h00;
  end
endmodule

// [rtl/uabw_remote.sv]
// Purpose: Remote serial node: sends and receives 8-bit characters, sends wake breaks
// Assumes: Same divisor value as the device; one stop bit
// Notes:   A break is a held low of a chosen number of bit times
`timescale 1ns/1ps
module uabw_remote #(
  parameter int BREAK_BITS = 13
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // User side
  input  wire logic [15:0] divisor_i,
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        tx_valid_i,
  input  wire logic        break_i,
  output logic             tx_ready_o,
  output logic      [7:0]  rx_data_o,
  output logic             rx_valid_o,
  // Serial link
  uabw_link_if.remote      link
);
  logic [15:0] tcnt, rcnt;
  logic [4:0]  tbit;
  logic [9:0]  tshift;
  logic        busy, brk;
  logic [3:0]  rbit;
  logic [8:0]  rshift;
  logic        rbusy, r1, r2;

  // Break is all zero and long
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      brk <= 1'b0;
      tcnt <= 16'h0000;
      tbit <= 5'h00;
      tshift <= 10'h3ff;
    end else if (!busy) begin
      tcnt <= 16'h0000;
      if (break_i) begin
        busy <= 1'b1;
        brk <= 1'b1;
        tbit <= 5'(BREAK_BITS);
        tshift <= 10'h000;
      end else if (tx_valid_i) begin
        busy <= 1'b1;
        brk <= 1'b0;
        tbit <= 5'h0a;
        tshift <= {1'b1, tx_data_i, 1'b0};
      end
    end else if (tcnt == divisor_i) begin
      tcnt <= 16'h0000;
      tbit <= tbit - 5'h01;
      tshift <= brk ? 10'h000 : {1'b1, tshift[9:1]};
      if (tbit == 5'h01) begin
        busy <= 1'b0;
        tshift <= 10'h3ff;
      end
    end else tcnt <= tcnt + 16'h0001;
  end
  assign link.dev_rx = tshift[0];
  assign tx_ready_o  = !busy;

  always_ff @(posedge core_clk_i) begin
    r1 <= link.dev_tx;
    r2 <= r1;
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rbusy <= 1'b0;
      rcnt <= 16'h0000;
      rbit <= 4'h0;
      rshift <= 9'h000;
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (!rbusy) begin
        rcnt <= 16'h0000;
        rbit <= 4'h0;
        if (!r2) rbusy <= 1'b1;
      end else if (rcnt == (rbit == 4'h0 ? {1'b0, divisor_i[15:1]} : divisor_i)) begin
        rcnt <= 16'h0000;
        rbit <= rbit + 4'h1;
        rshift <= {r2, rshift[8:1]};
        if (rbit == 4'h9) begin
          rbusy <= 1'b0;
          rx_data_o <= rshift[8:1];
          rx_valid_o <= r2;
        end
      end else rcnt <= rcnt + 16'h0001;
    end
  end
endmodule

// [tb/uabw_asserts.sv]
// Purpose: Concurrent checks on the serial link and the register port
// Assumes: Bench programs a divisor of 7, so one bit lasts 8 clocks
// Notes:   Polarity writes are kept out of the bit-hold checks
`timescale 1ns/1ps
module uabw_asserts (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] rdata_o,
  input  wire logic       irq_o,
  // Link
  input  wire logic       dev_tx,
  input  wire logic       dev_rx
);
  logic pol_q;
  logic pol_wr_q;
  wire  pol_wr = wr_i && addr_i == uabw_pkg::REG_CONTROL_2;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of the polarity bit, so a write that flips it can be told from one that rewrites it
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      pol_q <= 1'b0;
    else if (pol_wr)
      pol_q <= wdata_i[uabw_pkg::C2_TX_POLARITY_INVERT];
  end
  always_ff @(posedge core_clk_i) begin
    pol_wr_q <= pol_wr && !rst_i;
  end
  reset_mark_a: assert property ($fell(rst_i) |-> dev_tx)
    else $error("tx line not at mark after reset");
  tx_bit_hold_a: assert property ($changed(dev_tx) && !pol_wr_q |=> $stable(dev_tx) [*7])
    else $error("tx bit shorter than 8 clocks");
  tx_start_a: assert property ($fell(dev_tx) && !pol_wr_q |-> !dev_tx [*8])
    else $error("tx start bit not a full space bit");
  rx_bit_hold_a: assert property ($changed(dev_rx) |=> $stable(dev_rx) [*7])
    else $error("rx bit shorter than 8 clocks");
  rx_start_a: assert property ($fell(dev_rx) |-> !dev_rx [*8])
    else $error("rx start bit not a full space bit");
  pol_flip_a: assert property (pol_wr && wdata_i[uabw_pkg::C2_TX_POLARITY_INVERT] != pol_q |=> $changed(dev_tx))
    else $error("polarity change did not move tx at once");
  irq_gate_a: assert property (wr_i && addr_i == uabw_pkg::REG_CONTROL_1 &&
    !(wdata_i[uabw_pkg::C1_GLOBAL] && wdata_i[uabw_pkg::C1_PERIPH]) |=> !irq_o)
    else $error("interrupt without global and peripheral enables");
  unmapped_read_a: assert property (rd_i && addr_i > uabw_pkg::REG_STATUS |=> rdata_o == 8'h00)
    else $error("unmapped read returned data");
endmodule

// [tb/test_uabw.sv]
// Purpose: Self-checking bench: device and remote node face each other
// Assumes: Divisor 7, so a bit is 8 clocks; remote frames are 8-bit
// Notes:   Auto-baud overflow needs a 65536-clock idle wait
`timescale 1ns/1ps
module test_uart_async_autobaud_wake;
  logic        core_clk_i;
  logic        rst_i;
  logic [3:0]  addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  rdata_o;
  logic        irq_o;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        brk;
  logic        tx_ready;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic [7:0]  rx_last;
  logic [7:0]  got;
  logic [10:0] frame;
  logic [2:0]  fmts [5];
  int          errors;
  int          checks;
  int          n;

  uabw_link_if uabw_link_if_i ();
  uabw_device uabw_device_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .link(uabw_link_if_i.device));
  uabw_remote #(.BREAK_BITS(13)) uabw_remote_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .divisor_i(16'h0007),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .break_i(brk), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .link(uabw_link_if_i.remote));
  uabw_asserts uabw_asserts_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .dev_tx(uabw_link_if_i.dev_tx),
    .dev_rx(uabw_link_if_i.dev_rx));

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (rx_valid === 1'b1)
      rx_last <= rx_data;
  end

  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string name, input logic [10:0] exp, input logic [10:0] seen);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stuck(input string name);
    check(name, 11'h001, 11'h000);
    results();
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check($sformatf("reg %0h", a), {3'h0, exp}, {3'h0, v});
  endtask
  // Remote user side: valid held until ready is seen at an edge
  task automatic send(input logic [7:0] d);
    int k;
    k = 0;
    @(posedge core_clk_i);
    tx_data  <= d;
    tx_valid <= 1'b1;
    #1;
    while (tx_ready !== 1'b1 && k < 500) begin
      @(posedge core_clk_i);
      #1;
      k++;
    end
    @(posedge core_clk_i);
    tx_valid <= 1'b0;
    if (k >= 500)
      stuck("remote ready");
  endtask
  task automatic pulse_break();
    @(posedge core_clk_i);
    brk <= 1'b1;
    @(posedge core_clk_i);
    brk <= 1'b0;
  endtask
  // Samples the tx wire near mid-bit: start, 9 bit slots, one more slot
  task automatic capture(output logic [10:0] f);
    int k;
    k = 0;
    while (uabw_link_if_i.dev_tx !== 1'b0 && k < 200) begin
      @(posedge core_clk_i);
      #1;
      k++;
    end
    if (k >= 200)
      stuck("tx start");
    cyc(3);
    #1;
    for (int i = 0; i < 11; i++) begin
      f[i] = uabw_link_if_i.dev_tx;
      cyc(8);
      #1;
    end
  endtask
  function automatic logic [10:0] frame_of(input logic [2:0] fmt, input logic [7:0] d);
    logic [10:0] f;
    f = 11'h7fe;
    if (fmt == uabw_pkg::FMT_7BIT)
      f[7:1] = d[6:0];
    else
      f[8:1] = d;
    case (fmt)
      uabw_pkg::FMT_EVEN: f[9] = ^d;
      uabw_pkg::FMT_ODD:  f[9] = ~^d;
      uabw_pkg::FMT_ADDR: f[9] = d[7];
      default: ;
    endcase
    return f;
  endfunction

  initial begin
    fmts = '{uabw_pkg::FMT_8BIT, uabw_pkg::FMT_7BIT, uabw_pkg::FMT_EVEN, uabw_pkg::FMT_ODD, uabw_pkg::FMT_ADDR};
    {rst_i, wr_i, rd_i, tx_valid, brk} = 5'h10;
    {addr_i, wdata_i, tx_data, rx_last} = '0;
    errors = 0;
    checks = 0;
    cyc(4);
    rst_i <= 1'b0;
    #1;
    check("tx idle", 11'h001, {10'h0, uabw_link_if_i.dev_tx});
    for (int a = 0; a < 10; a++)
      if (a != 5)
        rdc(a[3:0], 8'h00);
    rdc(4'hf, 8'h00);
    wr(uabw_pkg::REG_DIVISOR_LOW, 8'h07);
    wr(uabw_pkg::REG_DIVISOR_HIGH, 8'h00);
    rdc(uabw_pkg::REG_DIVISOR_LOW, 8'h07);
    // Polarity flips the idle line even with the module disabled
    wr(uabw_pkg::REG_CONTROL_2, 8'h01);
    check("tx inverted", 11'h000, {10'h0, uabw_link_if_i.dev_tx});
    cyc(8);
    wr(uabw_pkg::REG_CONTROL_2, 8'h00);
    check("tx restored", 11'h001, {10'h0, uabw_link_if_i.dev_tx});
    // The low pulse looked like a start bit; let the remote finish that frame
    cyc(90);
    for (int i = 0; i < 5; i++) begin
      wr(uabw_pkg::REG_CONTROL_0, 8'ha0 | {5'h00, fmts[i]});
      wr(uabw_pkg::REG_TX_BUFFER, 8'hb4 + i[7:0]);
      capture(frame);
      check("tx frame", frame_of(fmts[i], 8'hb4 + i[7:0]), frame);
      if (i == 0)
        check("remote rx", 11'h0b4, {3'h0, rx_last});
    end
    wr(uabw_pkg::REG_CONTROL_0, 8'h90);
    send(8'h3c);
    n = 0;
    do begin
      rd(uabw_pkg::REG_MODULE_FLAGS, got);
      n++;
    end while (got[uabw_pkg::MF_RXIF] !== 1'b1 && n < 100);
    if (n >= 100)
      stuck("rx flag");
    rdc(uabw_pkg::REG_RX_BUFFER, 8'h3c);
    rdc(uabw_pkg::REG_ERROR_FLAGS, 8'h00);
    // Even parity wants a zero ninth bit; the remote's stop bit lands there
    wr(uabw_pkg::REG_CONTROL_0, 8'h92);
    send(8'h3c);
    cyc(120);
    rdc(uabw_pkg::REG_ERROR_FLAGS, 8'h04);
    wr(uabw_pkg::REG_ERROR_FLAGS, 8'h00);
    wr(uabw_pkg::REG_MODULE_FLAGS, 8'h00);
    // Wake on break, awake and asleep
    for (int s = 0; s < 2; s++) begin
      rdc(uabw_pkg::REG_STATUS, 8'h03);
      wr(uabw_pkg::REG_CONTROL_1, s ? 8'h3b : 8'h1b);
      pulse_break();
      cyc(20);
      rd(uabw_pkg::REG_MODULE_FLAGS, got);
      check("wake flag", 11'h001, {10'h0, got[uabw_pkg::MF_WAKE_EVENT_FLAG]});
      check("rx flag", 11'h000, {10'h0, got[uabw_pkg::MF_RXIF]});
      check("wake irq", 11'h001, {10'h0, irq_o});
      rdc(uabw_pkg::REG_CONTROL_1, s ? 8'h3b : 8'h1b);
      cyc(13 * 8 + 20);
      rdc(uabw_pkg::REG_CONTROL_1, s ? 8'h3a : 8'h1a);
      wr(uabw_pkg::REG_CONTROL_1, 8'h0a);
      check("irq gated", 11'h000, {10'h0, irq_o});
      wr(uabw_pkg::REG_MODULE_FLAGS, 8'h00);
      rdc(uabw_pkg::REG_MODULE_FLAGS, 8'h00);
    end
    // Auto-baud overflow, then completion on the fifth falling edge
    wr(uabw_pkg::REG_ERROR_IE, 8'h01);
    wr(uabw_pkg::REG_CONTROL_1, 8'h1c);
    wr(uabw_pkg::REG_CONTROL_0, 8'hd0);
    pulse_break();
    cyc(66000);
    rd(uabw_pkg::REG_ERROR_FLAGS, got);
    check("overflow", 11'h001, {10'h0, got[uabw_pkg::EF_AUTOBAUD_OVERFLOW_FLAG]});
    check("overflow irq", 11'h001, {10'h0, irq_o});
    rd(uabw_pkg::REG_CONTROL_0, got);
    check("abd searching", 11'h001, {10'h0, got[uabw_pkg::C0_AUTOBAUD_ENABLE]});
    send(8'h55);
    cyc(100);
    rd(uabw_pkg::REG_MODULE_FLAGS, got);
    check("abd done", 11'h001, {10'h0, got[uabw_pkg::MF_AUTOBAUD_DONE_FLAG]});
    rd(uabw_pkg::REG_CONTROL_0, got);
    check("abd cleared", 11'h000, {10'h0, got[uabw_pkg::C0_AUTOBAUD_ENABLE]});
    rdc(uabw_pkg::REG_DIVISOR_LOW, 8'h07);
    rdc(uabw_pkg::REG_DIVISOR_HIGH, 8'h00);
    wr(uabw_pkg::REG_ERROR_FLAGS, 8'h00);
    wr(uabw_pkg::REG_MODULE_FLAGS, 8'h00);
    rd(uabw_pkg::REG_ERROR_FLAGS, got);
    check("overflow clear", 11'h000, {10'h0, got[uabw_pkg::EF_AUTOBAUD_OVERFLOW_FLAG]});
    rd(uabw_pkg::REG_MODULE_FLAGS, got);
    check("done clear", 11'h000, {10'h0, got[uabw_pkg::MF_AUTOBAUD_DONE_FLAG]});
    check("irq clear", 11'h000, {10'h0, irq_o});
    // Software abort of a search in progress
    wr(uabw_pkg::REG_CONTROL_0, 8'hd0);
    wr(uabw_pkg::REG_CONTROL_0, 8'h90);
    wr(uabw_pkg::REG_ERROR_FLAGS, 8'h00);
    rdc(uabw_pkg::REG_CONTROL_0, 8'h90);
    results();
  end
endmodule
